/* shared/htsl_pkg.sv */
// constants, types and state layout for the humidity/temperature sensor link host
// assumes one 250 MHz clock and a sensor on an open-drain data pin with pull-up
`default_nettype none
package htsl_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS   = 4;
  localparam int HALF_NS  = 500;
  localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_MS  = 11;
  localparam int WAKE_CYC = (WAKE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int REST_MS  = 1000;
  localparam int REST_CYC = (REST_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W    = 28;
  localparam int DIV_W    = 8;
  localparam logic [3:0] LAST_BIT   = 4'h7;
  localparam logic [3:0] ACK_SLOT   = 4'h8;
  localparam logic [3:0] CONN_SLOTS = 4'h9;
  // ----------------------------------------
  // sensor commands (address 000 in the top bits)
  // ----------------------------------------
  localparam logic [7:0] CMD_MEAS_T = 8'h03;
  localparam logic [7:0] CMD_MEAS_H = 8'h05;
  localparam logic [7:0] CMD_RD_ST  = 8'h07;
  localparam logic [7:0] CMD_WR_ST  = 8'h06;
  localparam logic [7:0] CMD_SRST   = 8'h1E;
  localparam logic [7:0] ST_WMASK   = 8'h07;
  localparam logic [7:0] CRC_POLY   = 8'h31;
  localparam logic [7:0] CRC_INIT   = 8'h00;
  // ----------------------------------------
  // host register map and fields
  // ----------------------------------------
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_WST   = 8'h04;
  localparam logic [7:0] A_STAT  = 8'h08;
  localparam logic [7:0] A_RES   = 8'h0C;
  localparam logic [7:0] A_CRC   = 8'h10;
  localparam logic [7:0] A_RDST  = 8'h14;
  localparam int CTRL_CRC_BIT = 3;
  localparam logic [2:0] OP_MEAS_T = 3'h0;
  localparam logic [2:0] OP_MEAS_H = 3'h1;
  localparam logic [2:0] OP_RD_ST  = 3'h2;
  localparam logic [2:0] OP_WR_ST  = 3'h3;
  localparam logic [2:0] OP_SRST   = 3'h4;
  localparam logic [2:0] OP_CONN   = 3'h5;

  typedef enum logic [2:0] {S_PWR, S_IDLE, S_START, S_TX, S_WRDY, S_RX, S_HOLD, S_CRST}
    htsl_state_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } htsl_req_type;

  typedef struct packed {
    htsl_state_type   st;
    logic [DIV_W-1:0] div;
    logic             ph;
    logic [3:0]       bitn;
    logic [1:0]       bidx;
    logic [1:0]       nb;
    logic             first;
    logic [7:0]       shreg;
    logic [7:0]       crc;
    logic             sy1;
    logic             sy2;
    logic             seen_hi;
    logic             sck;
    logic             oe;
    logic [2:0]       op;
    logic             use_crc;
    logic [7:0]       wst;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] rest;
    logic             done;
    logic             ack_err;
    logic             crc_err;
    logic             refused;
    logic [15:0]      res;
    logic [7:0]       crc_rx;
    logic [7:0]       st_rd;
    logic [31:0]      rdata;
  } htsl_q_type;
endpackage
`default_nettype wire

/* tb/htsl_sensor_model.sv */
// behavioural sensor at the far end of the two-wire humidity/temperature link
// assumes the bench resolves the open-drain data line with a pull-up
`default_nettype none
module htsl_sensor_model #(
  parameter int WAKE = 40
) (
  input  wire logic        clk,
  input  wire logic        sck,
  input  wire logic        dline,
  input  wire logic [15:0] meas_val,
  input  wire logic [15:0] conv_cyc,
  input  wire logic        low_supply,
  input  wire logic        crc_flip,
  input  wire logic        nack,
  output logic             pull_low,
  output logic [7:0]       last_cmd
);
  timeunit 1ns;
  timeprecision 100ps;
  typedef enum logic [2:0] {M_IDLE, M_CMD, M_ACK, M_CONV, M_TX, M_RXW} htsl_mode_type;
  htsl_mode_type mode = M_IDLE;
  logic [7:0]    sh;
  logic [7:0]    crc;
  logic [7:0]    tx [0:2];
  logic [7:0]    st = 8'h00;
  logic [15:0]   v;
  logic          acked = 1'b0;
  logic          rxw = 1'b0;
  realtime       t_sck = 0;
  realtime       t_d;
  int            n = 0, k = 0, bi = 0, nb = 0, w = 0;
  int            wake_left = WAKE;
  int            conv_left = 0;
  initial pull_low = 1'b0;
  initial last_cmd = 8'h00;

  function automatic logic [7:0] crc_b(input logic [7:0] c, input logic [7:0] b);
    c ^= b;
    for (int i = 0; i < 8; i++) c = c[7] ? ((c << 1) ^ 8'h31) : (c << 1);
    return c;
  endfunction

  // checksum goes out bit-reversed, as the host expects
  task automatic load(input int cnt, input logic [7:0] b0, input logic [7:0] b1);
    crc = crc_b(crc_b(8'h00, last_cmd), b0);
    if (cnt == 3) crc = crc_b(crc, b1);
    crc = {<<{crc}};
    crc[0] = crc[0] ^ crc_flip;
    tx[0] = b0;
    tx[1] = (cnt == 3) ? b1 : crc;
    tx[2] = crc;
    nb = cnt;
    bi = 0;
    k = 1;
    mode = M_TX;
    pull_low = ~b0[7];
  endtask

  // falling edge keeps the ready pull off the host's sampling edge
  always @(negedge clk) begin
    if (wake_left > 0) wake_left = wake_left - 1;
    if (mode == M_CONV && conv_left > 0) conv_left = conv_left - 1;
    else if (mode == M_CONV) begin
      st[6] = low_supply;
      w = last_cmd[2] ? (st[0] ? 8 : 12) : (st[0] ? 12 : 14);
      v = meas_val & 16'((32'h1 << w) - 1);
      load(3, v[15:8], v[7:0]);
    end
  end

  // ----------------------------------------
  // link edges
  // ----------------------------------------
  always @(sck) t_sck = $realtime;

  // wait out same-step races so a bit change at a falling edge is no start
  always @(posedge dline) begin
    t_d = $realtime;
    #1;
    if (sck && dline && t_sck < t_d) begin
      mode = M_CMD;
      n = 0;
      pull_low = 1'b0;
    end
  end

  always @(posedge sck) begin
    if (mode == M_CMD || mode == M_RXW) begin
      sh = {sh[6:0], dline};
      n++;
    end
    if (mode == M_TX && k == 9) acked = ~dline;
  end

  always @(negedge sck) begin
    case (mode)
      M_CMD: if (n == 8) begin
        last_cmd = sh;
        mode = M_IDLE;
        if (wake_left == 0 && !nack && sh inside {8'h03, 8'h05, 8'h06, 8'h07, 8'h1E}) begin
          mode = M_ACK;
          pull_low = 1'b1;
        end
      end
      M_RXW: if (n == 8) begin
        st = {sh[7], st[6], sh[5:0]};
        rxw = 1'b1;
        mode = M_ACK;
        pull_low = 1'b1;
      end
      M_ACK: begin
        pull_low = 1'b0;
        mode = M_IDLE;
        if (rxw) rxw = 1'b0;
        else case (last_cmd)
          8'h03, 8'h05: begin
            mode = M_CONV;
            conv_left = st[1] ? conv_cyc * 3 / 4 : conv_cyc;
          end
          8'h07: load(2, st, 8'h00);
          8'h06: begin
            mode = M_RXW;
            n = 0;
          end
          8'h1E: begin
            st = {1'b0, st[6], 6'h00};
            wake_left = WAKE;
          end
          default: ;
        endcase
      end
      M_TX: if (k < 8) begin
        pull_low = ~tx[bi][7-k];
        k++;
      end else if (k == 8) begin
        pull_low = 1'b0;
        k = 9;
      end else if (acked && bi + 1 < nb) begin
        bi++;
        pull_low = ~tx[bi][7];
        k = 1;
      end else begin
        pull_low = 1'b0;
        mode = M_IDLE;
      end
      default: ;
    endcase
  end
endmodule // htsl_sensor_model
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the sensor link host
// assumes htsl_pkg, htsl_host and the sensor model are compiled first
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                   clk = 1'b0;
  logic                   rst_b = 1'b0;
  htsl_pkg::htsl_req_type req = '0;
  logic [31:0]            rdata;
  logic                   sck, data_o, data_oe, pull_low;
  logic [7:0]             last_cmd;
  wire logic              dline;
  logic [15:0]            meas_val = 16'h0000;
  logic [15:0]            conv_cyc = 16'h0010;
  logic                   low_supply = 1'b0, crc_flip = 1'b0, nack = 1'b0;
  logic [31:0]            seed = 32'h0000C6CA;
  int                     error_cnt = 0, num_checks = 0, sck_rises = 0;

  assign dline = ~((data_oe & ~data_o) | pull_low);
  always #2 clk = ~clk;
  always @(posedge sck) sck_rises++;

  htsl_host #(.WAKE_CYC(50), .REST_CYC(100), .HALF_CYC(4)) dut_u (
    .clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata), .sck(sck),
    .data_i(dline), .data_o(data_o), .data_oe(data_oe));
  htsl_sensor_model #(.WAKE(40)) sens_u (
    .clk(clk), .sck(sck), .dline(dline), .meas_val(meas_val), .conv_cyc(conv_cyc),
    .low_supply(low_supply), .crc_flip(crc_flip), .nack(nack), .pull_low(pull_low),
    .last_cmd(last_cmd));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] exp_res(input logic hum, input logic lo, input logic [15:0] v);
    int w;
    w = hum ? (lo ? 8 : 12) : (lo ? 12 : 14);
    return {16'h0000, v & 16'((32'h1 << w) - 1)};
  endfunction

  task automatic summarize();
    if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] e);
    num_checks++;
    if (got !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, got);
    end
  endtask

  // one idle cycle after each strobe keeps every signal to one assignment per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
    @(posedge clk);
  endtask

  task automatic wait_stat(input int b, input logic v, output logic [31:0] s);
    for (int i = 0; i < 3000; i++) begin
      rd(htsl_pkg::A_STAT, s);
      if (s[b] === v) return;
    end
    error_cnt++;
    $display("[FAIL] status bit %0d expected %b seen %b", b, v, s[b]);
    summarize();
  endtask

  task automatic run(input logic [2:0] op, input logic c, output logic [31:0] s);
    wr(htsl_pkg::A_CTRL, {28'h0, c, op});
    wait_stat(1, 1'b1, s);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic [7:0]  w;
    logic        lb;
    int          b;
    w = 8'h00;
    lb = 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(htsl_pkg::A_STAT, d);
    chk("busy in wake", d[0], 1'b1);
    wr(htsl_pkg::A_CTRL, 32'h0);
    rd(htsl_pkg::A_STAT, d);
    chk("refused in wake", d[5], 1'b1);
    chk("no clock in wake", sck_rises, 0);
    rd(8'h20, d);
    chk("unmapped read", d, 32'h0);
    wait_stat(0, 1'b0, d);
    wr(htsl_pkg::A_CTRL, 32'h6);
    rd(htsl_pkg::A_STAT, d);
    chk("bad op refused", d[5], 1'b1);
    for (int i = 0; i < 8; i++) begin
      if (i % 4 == 0) begin
        w = 8'(rnd());
        w[0] = i[2];
        wr(htsl_pkg::A_WST, {24'h0, w});
        run(htsl_pkg::OP_WR_ST, 1'b0, d);
        chk("status write cmd", last_cmd, 8'h06);
        chk("status write ack", d[2], 1'b0);
      end
      meas_val <= 16'(rnd());
      conv_cyc <= 16'h0010 + 16'(rnd() % 200);
      lb = 1'(rnd());
      low_supply <= lb;
      crc_flip <= (i == 7);
      run(i[0] ? htsl_pkg::OP_MEAS_H : htsl_pkg::OP_MEAS_T, i[1], d);
      chk("measure cmd", last_cmd, i[0] ? 8'h05 : 8'h03);
      chk("measure crc error", d[3], i == 7);
      chk("measure ack error", d[2], 1'b0);
      rd(htsl_pkg::A_RES, d);
      chk("result", d, exp_res(i[0], w[0], meas_val));
      if (i == 0) begin
        wr(htsl_pkg::A_CTRL, 32'h0);
        rd(htsl_pkg::A_STAT, d);
        chk("measure while resting", d[5], 1'b1);
      end
      wait_stat(4, 1'b0, d);
    end
    crc_flip <= 1'b0;
    run(htsl_pkg::OP_RD_ST, 1'b1, d);
    chk("status crc", d[3], 1'b0);
    rd(htsl_pkg::A_RDST, d);
    chk("status read", d, {1'b0, lb, 3'b000, w[2:0]});
    rd(htsl_pkg::A_WST, d);
    chk("status byte masked", d, {29'h0, w[2:0]});
    b = sck_rises;
    run(htsl_pkg::OP_CONN, 1'b0, d);
    chk("reset clocks", sck_rises - b, 9);
    run(htsl_pkg::OP_RD_ST, 1'b0, d);
    rd(htsl_pkg::A_RDST, d);
    chk("status kept", d, {1'b0, lb, 3'b000, w[2:0]});
    run(htsl_pkg::OP_SRST, 1'b0, d);
    chk("soft reset cmd", last_cmd, 8'h1E);
    run(htsl_pkg::OP_RD_ST, 1'b0, d);
    rd(htsl_pkg::A_RDST, d);
    chk("status cleared", d, {1'b0, lb, 6'h00});
    nack <= 1'b1;
    wr(htsl_pkg::A_CTRL, {29'h0, htsl_pkg::OP_RD_ST});
    wr(htsl_pkg::A_CTRL, {29'h0, htsl_pkg::OP_WR_ST});
    wait_stat(1, 1'b1, d);
    chk("refused while busy", d[5], 1'b1);
    chk("missing ack", d[2], 1'b1);
    nack <= 1'b0;
    rd(htsl_pkg::A_CTRL, d);
    chk("op after refusal", d, {29'h0, htsl_pkg::OP_RD_ST});
    summarize();
  end
endmodule // tb_top
`default_nettype wire

/* verilog/htsl_host.sv */
// host controller for the two-wire humidity/temperature sensor link
// assumes data pin is open drain with external pull-up; sck is driven from here
//
// Local design decisions: the strobed register port and the register addresses.
`default_nettype none
module htsl_host #(
  parameter int WAKE_CYC = htsl_pkg::WAKE_CYC,
  parameter int REST_CYC = htsl_pkg::REST_CYC,
  parameter int HALF_CYC = htsl_pkg::HALF_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire htsl_pkg::htsl_req_type req,
  output logic [31:0]                rdata,
  output logic                       sck,
  input  wire logic                  data_i,
  output logic                       data_o,
  output logic                       data_oe
);
  localparam logic [htsl_pkg::CNT_W-1:0] WAKE_M1  = htsl_pkg::CNT_W'(WAKE_CYC - 1);
  localparam logic [htsl_pkg::CNT_W-1:0] REST_LD  = htsl_pkg::CNT_W'(REST_CYC);
  localparam logic [htsl_pkg::DIV_W-1:0] DIV_LAST = htsl_pkg::DIV_W'(HALF_CYC - 1);

  htsl_pkg::htsl_q_type q;
  htsl_pkg::htsl_q_type d;
  logic                 tick;
  logic [7:0]           rx_byte;
  logic [7:0]           sh;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[7] ^ b;
    crc_step = {c[6:0], 1'b0} ^ (fb ? htsl_pkg::CRC_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = crc_step(r, b[i]);
    end
    crc_byte = r;
  endfunction

  function automatic logic [7:0] bit_rev(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      bit_rev[i] = b[7-i];
    end
  endfunction

  function automatic logic is_meas(input logic [2:0] op);
    is_meas = (op == htsl_pkg::OP_MEAS_T) || (op == htsl_pkg::OP_MEAS_H);
  endfunction

  function automatic logic [7:0] cmd_of(input logic [2:0] op);
    case (op)
      htsl_pkg::OP_MEAS_T: cmd_of = htsl_pkg::CMD_MEAS_T;
      htsl_pkg::OP_MEAS_H: cmd_of = htsl_pkg::CMD_MEAS_H;
      htsl_pkg::OP_RD_ST:  cmd_of = htsl_pkg::CMD_RD_ST;
      htsl_pkg::OP_WR_ST:  cmd_of = htsl_pkg::CMD_WR_ST;
      default:             cmd_of = htsl_pkg::CMD_SRST;
    endcase
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d       = q;
    tick    = (q.div == DIV_LAST);
    rx_byte = {q.shreg[6:0], q.sy2};
    sh      = {q.shreg[6:0], 1'b0};
    d.div   = tick ? '0 : q.div + 8'h01;
    d.sy1   = data_i;
    d.sy2   = q.sy1;
    d.rdata = '0;
    if (q.rest != '0) begin
      d.rest = q.rest - 28'h0000001;
    end

    if (req.rd) begin
      case (req.addr)
        htsl_pkg::A_CTRL: d.rdata = {28'h0000000, q.use_crc, q.op};
        htsl_pkg::A_WST:  d.rdata = {24'h000000, q.wst};
        htsl_pkg::A_STAT: d.rdata = {26'h0000000, q.refused, (q.rest != '0), q.crc_err,
                                     q.ack_err, q.done, (q.st != htsl_pkg::S_IDLE)};
        htsl_pkg::A_RES:  d.rdata = {16'h0000, q.res};
        htsl_pkg::A_CRC:  d.rdata = {24'h000000, q.crc_rx};
        htsl_pkg::A_RDST: d.rdata = {24'h000000, q.st_rd};
        default:          d.rdata = '0;
      endcase
    end
    if (req.wr && req.addr == htsl_pkg::A_WST) begin
      d.wst = req.wdata[7:0] & htsl_pkg::ST_WMASK;
    end
    if (req.wr && req.addr == htsl_pkg::A_CTRL) begin
      // measurements inside the rest window are refused to limit self-heating
      if (q.st != htsl_pkg::S_IDLE || req.wdata[2:0] > htsl_pkg::OP_CONN
          || (is_meas(req.wdata[2:0]) && q.rest != '0)) begin
        d.refused = 1'b1;
      end else begin
        d.op      = req.wdata[2:0];
        d.use_crc = req.wdata[htsl_pkg::CTRL_CRC_BIT];
        d.done    = 1'b0;
        d.ack_err = 1'b0;
        d.crc_err = 1'b0;
        d.refused = 1'b0;
        d.crc     = htsl_pkg::CRC_INIT;
        d.bitn    = '0;
        d.ph      = 1'b0;
        d.sck     = 1'b0;
        d.oe      = 1'b0;
        d.st      = (req.wdata[2:0] == htsl_pkg::OP_CONN) ? htsl_pkg::S_CRST
                                                          : htsl_pkg::S_START;
      end
    end

    case (q.st)
      htsl_pkg::S_PWR, htsl_pkg::S_HOLD: begin
        d.cnt = q.cnt + 28'h0000001;
        if (q.cnt == WAKE_M1) begin
          d.cnt  = '0;
          d.st   = htsl_pkg::S_IDLE;
          d.done = (q.st == htsl_pkg::S_HOLD);
        end
      end
      htsl_pkg::S_IDLE: begin
        d.sck = 1'b0;
        d.oe  = 1'b0;
      end
      htsl_pkg::S_START: if (tick) begin
        d.bitn = q.bitn + 4'h1;
        case (q.bitn)
          4'h0: d.sck = 1'b1;
          4'h1: d.oe  = 1'b1;
          4'h2: d.sck = 1'b0;
          4'h3: d.sck = 1'b1;
          4'h4: d.oe  = 1'b0;
          default: begin
            d.sck   = 1'b0;
            d.st    = htsl_pkg::S_TX;
            d.bitn  = '0;
            d.ph    = 1'b0;
            d.first = 1'b1;
            d.shreg = cmd_of(q.op);
            d.oe    = ~d.shreg[7];
          end
        endcase
      end
      htsl_pkg::S_TX: if (tick) begin
        if (!q.ph) begin
          d.sck = 1'b1;
          d.ph  = 1'b1;
        end else begin
          d.sck = 1'b0;
          d.ph  = 1'b0;
          if (q.bitn != htsl_pkg::ACK_SLOT) begin
            if (q.first) begin
              d.crc = crc_step(q.crc, q.shreg[7]);
            end
            d.shreg = sh;
            d.bitn  = q.bitn + 4'h1;
            d.oe    = (q.bitn == htsl_pkg::LAST_BIT) ? 1'b0 : ~sh[7];
          end else if (q.sy2) begin
            d.ack_err = 1'b1;
            d.done    = 1'b1;
            d.st      = htsl_pkg::S_IDLE;
          end else begin
            d.bitn = '0;
            case (q.op)
              htsl_pkg::OP_MEAS_T, htsl_pkg::OP_MEAS_H: begin
                d.seen_hi = 1'b0;
                d.nb      = q.use_crc ? 2'h3 : 2'h2;
                d.st      = htsl_pkg::S_WRDY;
              end
              htsl_pkg::OP_RD_ST: begin
                d.nb = q.use_crc ? 2'h2 : 2'h1;
                d.st = htsl_pkg::S_RX;
              end
              htsl_pkg::OP_WR_ST: begin
                if (q.first) begin
                  d.first = 1'b0;
                  d.shreg = q.wst;
                  d.oe    = ~q.wst[7];
                end else begin
                  d.done = 1'b1;
                  d.st   = htsl_pkg::S_IDLE;
                end
              end
              default: begin
                d.cnt = '0;
                d.st  = htsl_pkg::S_HOLD;
              end
            endcase
            d.bidx = '0;
          end
        end
      end
      htsl_pkg::S_WRDY: begin
        // the ack low may still sit in the synchroniser, so wait for a high first
        if (q.sy2) begin
          d.seen_hi = 1'b1;
        end
        if (q.seen_hi && !q.sy2) begin
          d.st = htsl_pkg::S_RX;
          d.ph = 1'b0;
        end
      end
      htsl_pkg::S_RX: if (tick) begin
        if (!q.ph) begin
          d.sck = 1'b1;
          d.ph  = 1'b1;
        end else begin
          d.sck = 1'b0;
          d.ph  = 1'b0;
          if (q.bitn != htsl_pkg::ACK_SLOT) begin
            d.shreg = rx_byte;
            d.bitn  = q.bitn + 4'h1;
            if (q.bitn == htsl_pkg::LAST_BIT) begin
              d.oe = ((q.bidx + 2'h1) != q.nb);
              if (is_meas(q.op) && q.bidx == 2'h0) begin
                d.res[15:8] = rx_byte;
              end else if (is_meas(q.op) && q.bidx == 2'h1) begin
                d.res[7:0] = rx_byte;
              end else if (!is_meas(q.op) && q.bidx == 2'h0) begin
                d.st_rd = rx_byte;
              end else begin
                d.crc_rx = rx_byte;
              end
              if (q.bidx != (is_meas(q.op) ? 2'h2 : 2'h1)) begin
                d.crc = crc_byte(q.crc, rx_byte);
              end
            end
          end else begin
            d.oe   = 1'b0;
            d.bitn = '0;
            d.bidx = q.bidx + 2'h1;
            if ((q.bidx + 2'h1) == q.nb) begin
              d.st      = htsl_pkg::S_IDLE;
              d.done    = 1'b1;
              d.crc_err = q.use_crc && (q.crc_rx != bit_rev(q.crc));
              if (is_meas(q.op)) begin
                d.rest = REST_LD;
              end
            end
          end
        end
      end
      htsl_pkg::S_CRST: if (tick) begin
        d.oe = 1'b0;
        if (!q.ph) begin
          d.sck = 1'b1;
          d.ph  = 1'b1;
        end else begin
          d.sck  = 1'b0;
          d.ph   = 1'b0;
          d.bitn = q.bitn + 4'h1;
          if (q.bitn == (htsl_pkg::CONN_SLOTS - 4'h1)) begin
            d.st   = htsl_pkg::S_IDLE;
            d.done = 1'b1;
          end
        end
      end
      default: d.st = htsl_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q    <= '0;
      q.st <= htsl_pkg::S_PWR;
    end else begin
      q <= d;
    end
  end

  assign rdata   = q.rdata;
  assign sck     = q.sck;
  assign data_o  = 1'b0;
  assign data_oe = q.oe;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_hold8;
    (q.st == htsl_pkg::S_HOLD)[*8];
  endsequence

  property p_start_low;
    ($rose(q.oe) && q.st == htsl_pkg::S_START) |-> q.sck;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start low not under sck high");

  property p_start_rel;
    ($fell(q.oe) && q.st == htsl_pkg::S_START) |-> q.sck && q.bitn == 4'h5;
  endproperty
  a_start_rel: assert property (p_start_rel) else $error("start release misplaced");

  property p_cmd_addr;
    (q.st == htsl_pkg::S_TX && q.first && q.bitn < 4'h3) |-> q.oe;
  endproperty
  a_cmd_addr: assert property (p_cmd_addr) else $error("address bits not zero");

  property p_hold_high;
    (q.sck && $past(q.sck) && q.st != htsl_pkg::S_START) |-> $stable(q.oe);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("data moved while sck high");

  property p_rdy_wait;
    q.st == htsl_pkg::S_WRDY |-> !q.sck && !q.oe;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("clocked before data ready");

  property p_host_ack;
    (q.st == htsl_pkg::S_RX && q.bitn == htsl_pkg::ACK_SLOT && q.sck)
      |-> q.oe == ((q.bidx + 2'h1) != q.nb);
  endproperty
  a_host_ack: assert property (p_host_ack) else $error("wrong host ack level");

  property p_wake;
    (q.st == htsl_pkg::S_PWR && q.cnt != WAKE_M1) |=> q.st == htsl_pkg::S_PWR;
  endproperty
  a_wake: assert property (p_wake) else $error("left power-up wait early");

  property p_srst_wait;
    $rose(q.st == htsl_pkg::S_HOLD) |-> q.cnt == '0 ##0 s_hold8;
  endproperty
  a_srst_wait: assert property (p_srst_wait) else $error("soft reset wait cut short");

  property p_conn_rst;
    $fell(q.st == htsl_pkg::S_CRST) |-> q.bitn == htsl_pkg::CONN_SLOTS && !q.oe;
  endproperty
  a_conn_rst: assert property (p_conn_rst) else $error("recovery clock count wrong");

  property p_rest;
    (q.rest != '0) |-> !(q.st == htsl_pkg::S_START && is_meas(q.op) && q.bitn == 4'h0
                         && $changed(q.st));
  endproperty
  a_rest: assert property (p_rest) else $error("measurement inside rest window");
endmodule // htsl_host
`default_nettype wire
